// File: common/twsc_defs.vh
`ifndef TWSC_DEFS_VH
`define TWSC_DEFS_VH
// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TWSC_ADDR_CTRL 12'h000
`define TWSC_ADDR_STAT 12'h004
`define TWSC_ADDR_LAST 12'h008
`define TWSC_CTRL_RST 32'h0000_0002
`define TWSC_MODE_LSB 0
`define TWSC_MODE_MSB 1
`define TWSC_TAG2K_BIT 2
`define TWSC_CONF_BIT 3
`define TWSC_MODE_CONT 2'h0
`define TWSC_MODE_TRIG 2'h2
// ---------------------------------------------------------------
// characters
// ---------------------------------------------------------------
`define TWSC_CH_W 8'h57
`define TWSC_CH_D 8'h44
`define TWSC_CH_SP 8'h20
`define TWSC_CH_CR 8'h0d
`define TWSC_CH_0 8'h30
`define TWSC_CH_9 8'h39
`define TWSC_CH_UA 8'h41
`define TWSC_CH_UF 8'h46
`define TWSC_CH_LA 8'h61
`define TWSC_CH_LF 8'h66
`define TWSC_CH_X 8'h58
`define TWSC_CH_C 8'h43
`define TWSC_CH_K 8'h4b
`define TWSC_CH_N 8'h4e
`define TWSC_CH_O 8'h4f
`define TWSC_CH_T 8'h54
// ---------------------------------------------------------------
// block limits, reply kinds, tag write results
// ---------------------------------------------------------------
`define TWSC_BLK1K_MIN 7'h03
`define TWSC_BLK1K_MAX 7'h1f
`define TWSC_BLK2K_MIN 7'h10
`define TWSC_BLK2K_MAX 7'h3f
`define TWSC_BLK_CAP 7'h63
`define TWSC_HEX_CHARS 4'h8
`define TWSC_MSG_ACK 3'h0
`define TWSC_MSG_NAK 3'h1
`define TWSC_MSG_NOT 3'h2
`define TWSC_MSG_ID 3'h3
`define TWSC_MSG_EMPTY 3'h4
`define TWSC_LEN_SHORT 4'h3
`define TWSC_LEN_LONG 4'h8
`define TWSC_WR_OK 2'h0
`define TWSC_WR_FAIL 2'h1
`define TWSC_WR_UNREAD 2'h2
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TWSC_CLK_NS 10
`define TWSC_SCAN_GAP_NS 10000000
`define TWSC_SCAN_GAP_CYC (`TWSC_SCAN_GAP_NS / `TWSC_CLK_NS)
`endif

// File: hw/twsc_top.v
// Functional notes
// - tag memory is 32-bit blocks; one block written per command.
// - a space separates block number and data; parser splits there.
// - every write attempt returns three characters plus CR.
// - acknowledge on success, refusal on failed write.
// - reply NOT when tag answer after write is undecodable.
// - success lamp after good write, failure lamp otherwise.
// - blocks 3..31 for 1 kbit tags, 16..63 for 2 kbit tags.
// - continuous mode keeps the excitation field on all the time.
// - continuous mode starts read cycles periodically by itself.
// - after each scan cycle send tag number or empty-read code; with confirm on, an unconfirmed read sends nothing.
// - mode select value 0 chooses continuous mode.
// - continuous mode reads only the tag serial number.
// - confirm on: report a tag only after two matching reads.
// - continuous mode lights success or failure lamp per reported read; an unconfirmed read with confirm on leaves both lamps.
// - writes accepted in every mode except continuous (0); field off when idle.
`include "twsc_defs.vh"
module twsc_top #(
  parameter SCAN_GAP_CYC = `TWSC_SCAN_GAP_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready,
  output reg field_on,
  output reg tag_wr_req,
  output reg [5:0] tag_wr_block,
  output reg [31:0] tag_wr_data,
  input wire tag_wr_done,
  input wire [1:0] tag_wr_result,
  output reg tag_rd_start,
  input wire tag_rd_done,
  input wire tag_rd_ok,
  input wire [31:0] tag_rd_id,
  output reg success_lamp,
  output reg failure_lamp
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WRITE = 4'b0010;
  localparam [3:0] S_SCAN = 4'b0100;
  localparam [3:0] S_SEND = 4'b1000;
  localparam [2:0] P_W = 3'h0;
  localparam [2:0] P_D = 3'h1;
  localparam [2:0] P_SP = 3'h2;
  localparam [2:0] P_BLK = 3'h3;
  localparam [2:0] P_HEX = 3'h4;

  // ---------------------------------------------------------------
  // character helpers
  // ---------------------------------------------------------------
  function is_hex;
    input [7:0] c;
    begin
      is_hex = (c >= `TWSC_CH_0 && c <= `TWSC_CH_9) ||
        (c >= `TWSC_CH_UA && c <= `TWSC_CH_UF) ||
        (c >= `TWSC_CH_LA && c <= `TWSC_CH_LF);
    end
  endfunction
  function [3:0] hex_val;
    input [7:0] c;
    reg [7:0] t;
    begin
      t = 8'h00;
      if (c <= `TWSC_CH_9)
        t = c - `TWSC_CH_0;
      else if (c <= `TWSC_CH_UF)
        t = c - `TWSC_CH_UA + 8'h0a;
      else
        t = c - `TWSC_CH_LA + 8'h0a;
      hex_val = t[3:0];
    end
  endfunction

  function [7:0] nib_char;
    input [3:0] n;
    begin
      if (n < 4'ha)
        nib_char = `TWSC_CH_0 + {4'h0, n};
      else
        nib_char = `TWSC_CH_UA + {4'h0, n} - 8'h0a;
    end
  endfunction

  function [7:0] msg_char;
    input [2:0] kind;
    input [3:0] idx;
    input [31:0] id;
    reg [31:0] sh;
    begin
      sh = id << {idx, 2'b00};
      msg_char = `TWSC_CH_CR;
      case (kind)
        `TWSC_MSG_ACK:
          if (idx == 4'h0) msg_char = `TWSC_CH_UA;
          else if (idx == 4'h1) msg_char = `TWSC_CH_C;
          else if (idx == 4'h2) msg_char = `TWSC_CH_K;
        `TWSC_MSG_NAK:
          if (idx == 4'h0) msg_char = `TWSC_CH_N;
          else if (idx == 4'h1) msg_char = `TWSC_CH_UA;
          else if (idx == 4'h2) msg_char = `TWSC_CH_K;
        `TWSC_MSG_NOT:
          if (idx == 4'h0) msg_char = `TWSC_CH_N;
          else if (idx == 4'h1) msg_char = `TWSC_CH_O;
          else if (idx == 4'h2) msg_char = `TWSC_CH_T;
        `TWSC_MSG_ID:
          if (idx < `TWSC_LEN_LONG) msg_char = nib_char(sh[31:28]);
        default:
          if (idx < `TWSC_LEN_LONG) msg_char = `TWSC_CH_X;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [31:0] ctrl_reg, data_reg, id_reg, prev_id_reg, gap_reg;
  reg [3:0] state_reg, ndig_reg, nhex_reg, idx_reg;
  reg [2:0] phase_reg, msg_reg;
  reg perr_reg, prev_ok_reg;
  reg [6:0] blk_reg;
  reg [1:0] last_res_reg;
  wire [1:0] mode = ctrl_reg[`TWSC_MODE_MSB:`TWSC_MODE_LSB];
  wire cont = (mode == `TWSC_MODE_CONT);
  wire tag2k = ctrl_reg[`TWSC_TAG2K_BIT];
  wire confirm = ctrl_reg[`TWSC_CONF_BIT];
  wire [6:0] blk_min = tag2k ? `TWSC_BLK2K_MIN : `TWSC_BLK1K_MIN;
  wire [6:0] blk_max = tag2k ? `TWSC_BLK2K_MAX : `TWSC_BLK1K_MAX;
  wire blk_ok = (blk_reg >= blk_min) && (blk_reg <= blk_max);
  wire is_dig = (rx_data >= `TWSC_CH_0) && (rx_data <= `TWSC_CH_9);
  wire [6:0] dig = {3'h0, rx_data[3:0]};
  wire [10:0] blk_mul = {4'h0, blk_reg} * 11'h00a + {4'h0, dig};
  wire cmd_good = !perr_reg && phase_reg == P_HEX &&
    nhex_reg == `TWSC_HEX_CHARS && blk_ok && !cont;
  wire msg_last = (msg_reg <= `TWSC_MSG_NOT) ?
    (idx_reg == `TWSC_LEN_SHORT) : (idx_reg == `TWSC_LEN_LONG);
  wire gap_done = (gap_reg >= SCAN_GAP_CYC - 1);
  // ---------------------------------------------------------------
  // apb slave: one wait state, reads answered from flops
  // ---------------------------------------------------------------
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == `TWSC_ADDR_CTRL);
  wire hit_stat = (paddr == `TWSC_ADDR_STAT);
  wire hit_last = (paddr == `TWSC_ADDR_LAST);
  wire hit = hit_ctrl || hit_stat || hit_last;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_reg :
    hit_stat ? {22'h0, last_res_reg, failure_lamp, success_lamp,
      field_on, state_reg, cont} : hit_last ? id_reg : 32'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_reg <= `TWSC_CTRL_RST;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      if (acc && !pready)
        prdata <= pwrite ? 32'h0 : rd_mux;
      if (acc && pready && pwrite && hit_ctrl)
        ctrl_reg <= {28'h0, pwdata[3:0]};
    end
  end
  // ---------------------------------------------------------------
  // command parser, scan loop and reply sender
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      phase_reg <= P_W;
      perr_reg <= 1'b0;
      blk_reg <= 7'h0;
      ndig_reg <= 4'h0;
      nhex_reg <= 4'h0;
      data_reg <= 32'h0;
      msg_reg <= `TWSC_MSG_NAK;
      idx_reg <= 4'h0;
      id_reg <= 32'h0;
      prev_id_reg <= 32'h0;
      prev_ok_reg <= 1'b0;
      gap_reg <= 32'h0;
      last_res_reg <= 2'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h0;
      field_on <= 1'b0;
      tag_wr_req <= 1'b0;
      tag_wr_block <= 6'h0;
      tag_wr_data <= 32'h0;
      tag_rd_start <= 1'b0;
      success_lamp <= 1'b0;
      failure_lamp <= 1'b0;
    end else begin
      tag_wr_req <= 1'b0;
      tag_rd_start <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          field_on <= cont;
          if (!cont)
            prev_ok_reg <= 1'b0;
          if (cont && gap_done) begin
            gap_reg <= 32'h0;
            tag_rd_start <= 1'b1;
            state_reg <= S_SCAN;
          end else if (cont) begin
            gap_reg <= gap_reg + 32'h1;
          end
          if (rx_valid && rx_data == `TWSC_CH_CR) begin
            phase_reg <= P_W;
            perr_reg <= 1'b0;
            blk_reg <= 7'h0;
            ndig_reg <= 4'h0;
            nhex_reg <= 4'h0;
            if (phase_reg != P_W || perr_reg) begin
              idx_reg <= 4'h0;
              state_reg <= S_SEND;
              if (cmd_good) begin
                tag_wr_req <= 1'b1;
                tag_wr_block <= blk_reg[5:0];
                tag_wr_data <= data_reg;
                field_on <= 1'b1;
                state_reg <= S_WRITE;
              end else begin
                msg_reg <= `TWSC_MSG_NAK;
                success_lamp <= 1'b0;
                failure_lamp <= 1'b1;
              end
            end
          end else if (rx_valid) begin
            case (phase_reg)
              P_W: begin
                phase_reg <= P_D;
                perr_reg <= rx_data != `TWSC_CH_W;
              end
              P_D: begin
                phase_reg <= P_SP;
                perr_reg <= perr_reg || rx_data != `TWSC_CH_D;
              end
              P_SP: begin
                phase_reg <= P_BLK;
                perr_reg <= perr_reg || rx_data != `TWSC_CH_SP;
              end
              P_BLK: begin
                if (rx_data == `TWSC_CH_SP) begin
                  phase_reg <= P_HEX;
                  perr_reg <= perr_reg || ndig_reg == 4'h0;
                end else if (is_dig && ndig_reg < 4'h2) begin
                  blk_reg <= blk_mul[6:0];
                  ndig_reg <= ndig_reg + 4'h1;
                end else begin
                  perr_reg <= 1'b1;
                end
              end
              default: begin
                if (is_hex(rx_data) && nhex_reg < `TWSC_HEX_CHARS) begin
                  data_reg <= {data_reg[27:0], hex_val(rx_data)};
                  nhex_reg <= nhex_reg + 4'h1;
                end else begin
                  perr_reg <= 1'b1;
                end
              end
            endcase
          end
        end
        S_WRITE: begin
          if (tag_wr_done) begin
            field_on <= cont;
            last_res_reg <= tag_wr_result;
            success_lamp <= tag_wr_result == `TWSC_WR_OK;
            failure_lamp <= tag_wr_result != `TWSC_WR_OK;
            if (tag_wr_result == `TWSC_WR_OK)
              msg_reg <= `TWSC_MSG_ACK;
            else if (tag_wr_result == `TWSC_WR_UNREAD)
              msg_reg <= `TWSC_MSG_NOT;
            else
              msg_reg <= `TWSC_MSG_NAK;
            state_reg <= S_SEND;
          end
        end
        S_SCAN: begin
          field_on <= 1'b1;
          if (tag_rd_done) begin
            if (!tag_rd_ok) begin
              prev_ok_reg <= 1'b0;
              msg_reg <= `TWSC_MSG_EMPTY;
              success_lamp <= 1'b0;
              failure_lamp <= 1'b1;
              state_reg <= S_SEND;
            end else if (confirm &&
                !(prev_ok_reg && prev_id_reg == tag_rd_id)) begin
              prev_ok_reg <= 1'b1;
              prev_id_reg <= tag_rd_id;
              state_reg <= S_IDLE;
            end else begin
              prev_ok_reg <= 1'b0;
              prev_id_reg <= tag_rd_id;
              id_reg <= tag_rd_id;
              msg_reg <= `TWSC_MSG_ID;
              success_lamp <= 1'b1;
              failure_lamp <= 1'b0;
              state_reg <= S_SEND;
            end
            idx_reg <= 4'h0;
          end
        end
        S_SEND: begin
          if (!tx_valid) begin
            tx_valid <= 1'b1;
            tx_data <= msg_char(msg_reg, idx_reg, id_reg);
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            idx_reg <= idx_reg + 4'h1;
            if (msg_last)
              state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // twsc_top

// File: verification/twsc_chk_sva.sv
`include "twsc_defs.vh"
module twsc_chk (
  input wire pclk,
  input wire presetn,
  input wire pready,
  input wire pslverr,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready,
  input wire field_on,
  input wire tag_wr_req,
  input wire [5:0] tag_wr_block,
  input wire tag_wr_done,
  input wire [1:0] tag_wr_result,
  input wire tag_rd_start,
  input wire tag_rd_done,
  input wire tag_rd_ok,
  input wire success_lamp,
  input wire failure_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  wr_req_pulse_a: assert property (tag_wr_req |=> !tag_wr_req)
    else $error("write request not a pulse");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("tx char dropped");
  lamp_good_a: assert property (tag_wr_done &&
    tag_wr_result == `TWSC_WR_OK |-> ##[1:2] success_lamp && !failure_lamp)
    else $error("success lamp not lit");
  lamp_fail_a: assert property (tag_wr_done &&
    tag_wr_result != `TWSC_WR_OK |-> ##[1:2] failure_lamp && !success_lamp)
    else $error("failure lamp not lit");
  scan_empty_a: assert property (tag_rd_done && !tag_rd_ok
    |-> ##[1:2] failure_lamp) else $error("empty read lamp wrong");
  block_floor_a: assert property (tag_wr_req |-> tag_wr_block >= 6'h03)
    else $error("block below range");
  field_scan_a: assert property (tag_rd_start |-> field_on [*5])
    else $error("field off during scan");
  rd_pulse_a: assert property (tag_rd_start |=> !tag_rd_start)
    else $error("read start not a pulse");
endmodule // twsc_chk

// File: verification/twsc_host.sv
`include "twsc_defs.vh"
module twsc_host (
  input wire pclk,
  input wire presetn,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // serial host
  // ---------------------------------------------------------------
  localparam bit DUP_FILTER = 1'b0;
  localparam bit EMPTY_SUPPRESS = 1'b0;
  bit slow = 1'b0;
  logic [7:0] rxq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_ready <= 1'b0;
    else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) rxq.push_back(tx_data);
    end
  end
  // one block per line, space before data, closing cr
  task send_line(input string s);
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= (i == s.len()) ? `TWSC_CH_CR : s[i];
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  endtask
  task get_line(output string s);
    int n;
    s = "";
    for (n = 0; n < 3000; n++) begin
      @(posedge pclk);
      if (rxq.size() != 0) begin
        if (rxq[0] == `TWSC_CH_CR) begin
          void'(rxq.pop_front());
          return;
        end
        s = {s, string'(rxq.pop_front())};
      end
    end
    s = "timeout";
  endtask
endmodule // twsc_host

// File: verification/tb.sv
`include "twsc_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, tag_wr_data, wr_dat, rd_id = 32'h0;
  logic [31:0] tag_rd_id = 32'h0;
  logic pready, pslverr, rx_valid, tx_valid, tx_ready, field_on, tag_wr_req;
  logic tag_rd_start, success_lamp, failure_lamp, rd_ok = 0;
  logic tag_wr_done = 0, tag_rd_done = 0, tag_rd_ok = 0;
  logic [7:0] rx_data, tx_data;
  logic [5:0] tag_wr_block, wr_blk;
  logic [1:0] tag_wr_result = 2'h0, wr_res = 2'h0;
  int mismatches = 0, tests_run = 0, wr_cnt = 0, rd_cnt = 0;
  int wr_wait = 0, rd_wait = 0;
  always #5 pclk = ~pclk;
  twsc_top #(.SCAN_GAP_CYC(20)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .field_on(field_on),
    .tag_wr_req(tag_wr_req), .tag_wr_block(tag_wr_block),
    .tag_wr_data(tag_wr_data), .tag_wr_done(tag_wr_done),
    .tag_wr_result(tag_wr_result), .tag_rd_start(tag_rd_start),
    .tag_rd_done(tag_rd_done), .tag_rd_ok(tag_rd_ok),
    .tag_rd_id(tag_rd_id), .success_lamp(success_lamp),
    .failure_lamp(failure_lamp));
  twsc_host host (.pclk(pclk), .presetn(presetn), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  // ---------------------------------------------------------------
  // tag models and checks
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    tag_wr_done <= 1'b0;
    tag_rd_done <= 1'b0;
    tag_rd_id <= ~tag_rd_id;
    tag_wr_result <= wr_res;
    if (tag_wr_req) begin
      wr_cnt++;
      wr_blk <= tag_wr_block;
      wr_dat <= tag_wr_data;
      wr_wait <= 3;
    end else if (wr_wait > 0) begin
      wr_wait <= wr_wait - 1;
      tag_wr_done <= (wr_wait == 1);
    end
    if (tag_rd_start) begin
      rd_cnt++;
      rd_wait <= 4;
    end else if (rd_wait > 0) begin
      rd_wait <= rd_wait - 1;
      if (rd_wait == 1) begin
        tag_rd_done <= 1'b1;
        tag_rd_ok <= rd_ok;
        tag_rd_id <= rd_id;
      end
    end
  end
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", w, e, g);
      mismatches++;
    end
  endtask
  task chks(input string w, input string e, input string g);
    tests_run++;
    if (g != e) begin
      $display("BAD %s expected %s seen %s", w, e, g);
      mismatches++;
    end
  endtask
  task automatic apb(input bit wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check_wd(input string cmd, input bit go,
    input logic [5:0] blk, input logic [31:0] dat, input logic [1:0] res);
    string s, e;
    int n0;
    wr_res = res;
    n0 = wr_cnt;
    host.send_line(cmd);
    host.get_line(s);
    e = !go ? "NAK" : res == 0 ? "ACK" : res == 1 ? "NAK" : "NOT";
    chks(cmd, e, s);
    chk("writes", go, wr_cnt - n0);
    if (go) begin
      chk("block", blk, wr_blk);
      chk("data", dat, wr_dat);
    end
    chk("ok lamp", go && res == 0, success_lamp);
    chk("fail lamp", !(go && res == 0), failure_lamp);
    chk("field idle", 0, field_on);
  endtask
  task t_regs;
    logic [31:0] q;
    logic e;
    apb(0, `TWSC_ADDR_CTRL, 32'h0, q, e);
    chk("ctrl reset", `TWSC_CTRL_RST, q);
    apb(1, 12'h00c, 32'h5, q, e);
    chk("unmapped err", 1, e);
    apb(0, 12'h00c, 32'h0, q, e);
    chk("unmapped data", 0, q);
  endtask
  task t_results;
    for (int r = 0; r < 3; r++)
      check_wd("WD 20 0127ACDF", 1, 20, 32'h0127acdf, r);
  endtask
  task t_range;
    logic [31:0] q;
    logic e;
    check_wd("WD 2 00000000", 0, 0, 0, 0);
    check_wd("WD 3 89abcdef", 1, 3, 32'h89abcdef, 0);
    check_wd("WD 31 FFFFFFFF", 1, 31, 32'hffffffff, 0);
    check_wd("WD 32 00000001", 0, 0, 0, 0);
    check_wd("WD 5 0127ACDG", 0, 0, 0, 0);
    apb(1, `TWSC_ADDR_CTRL, 32'h6, q, e);
    check_wd("WD 15 00000000", 0, 0, 0, 0);
    check_wd("WD 16 12345678", 1, 16, 32'h12345678, 1);
    check_wd("WD 63 0000000a", 1, 63, 32'h0000000a, 0);
  endtask
  task t_scan;
    logic [31:0] q;
    logic e;
    string s;
    int n0;
    host.slow = 1;
    rd_ok = 1;
    rd_id = 32'h1234abcd;
    apb(1, `TWSC_ADDR_CTRL, 32'h0, q, e);
    n0 = rd_cnt;
    host.get_line(s);
    chks("scan id", "1234ABCD", s);
    chk("reads", 1, rd_cnt - n0);
    chk("field", 1, field_on);
    chk("scan ok lamp", 1, success_lamp);
    apb(0, `TWSC_ADDR_LAST, 32'h0, q, e);
    chk("last id", 32'h1234abcd, q);
    apb(0, `TWSC_ADDR_STAT, 32'h0, q, e);
    chk("cont flag", 1, q[0]);
    rd_ok = 0;
    host.get_line(s);
    chks("empty", "XXXXXXXX", s);
    chk("scan fail lamp", 1, failure_lamp);
    rd_ok = 1;
    rd_id = 32'h0badf00d;
    apb(1, `TWSC_ADDR_CTRL, 32'h8, q, e);
    n0 = rd_cnt;
    host.get_line(s);
    chks("confirmed id", "0BADF00D", s);
    chk("confirm reads", 2, rd_cnt - n0);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_results;
    t_range;
    t_scan;
    finish_test;
  end
endmodule // tb
bind twsc_top twsc_chk chk (.pclk(pclk), .presetn(presetn), .pready(pready),
  .pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .field_on(field_on), .tag_wr_req(tag_wr_req),
  .tag_wr_block(tag_wr_block), .tag_wr_done(tag_wr_done),
  .tag_wr_result(tag_wr_result), .tag_rd_start(tag_rd_start),
  .tag_rd_done(tag_rd_done), .tag_rd_ok(tag_rd_ok),
  .success_lamp(success_lamp), .failure_lamp(failure_lamp));
